// >>> osc_pmc_pkg.sv
// Purpose: Shared constants for the oscillator and power-mode controller
// Assumes: APB register access, 32-bit data, one word per register
// Notes:   Offsets chosen for this block; see hand-over

package osc_pmc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_OSC_MODE   = 8'h00;
   localparam logic [7:0] OFS_IRQ_CTRL   = 8'h04;
   localparam logic [7:0] OFS_IRQ_FLAGS  = 8'h08;
   localparam logic [7:0] OFS_CONFIG     = 8'h0c;
   localparam logic [7:0] OFS_STATUS     = 8'h10;
   // oscillator_mode_control fields
   localparam int FLD_SEL_FAST = 0;
   localparam int FLD_STOP_FAST = 1;
   localparam int FLD_MODE_LO = 2;
   localparam int FLD_CMP_STATE = 4;
   // irq control / flag fields
   localparam int FLD_GIE = 0;
   localparam int FLD_LVD = 1;
   localparam int FLD_CMP = 2;
   localparam int FLD_ADC = 3;
   // config fields
   localparam int FLD_HRC_LO = 0;
   localparam int FLD_DIV4 = 3;
   localparam int FLD_START_FAST = 4;
   localparam int FLD_XTAL = 5;
   // Power mode field encodings
   localparam logic [1:0] PMODE_RUN     = 2'h0;
   localparam logic [1:0] PMODE_HALT    = 2'h1;
   localparam logic [1:0] PMODE_STANDBY = 2'h2;
   // Reset values
   localparam logic [7:0] RST_OSC_MODE  = 8'h01;
   localparam logic [7:0] RST_CONFIG    = 8'h10;
   // Fast RC choices in MHz, code 0..5
   localparam int FAST_RC_MHZ [6] = '{1, 2, 4, 8, 16, 20};
   localparam int SLOW_RC_HZ = 32768;
   // Wake-up stable times in system clock cycles
   localparam int WAKE_XTAL_CYC = 512;
   localparam int WAKE_RC_CYC   = 16;
   localparam logic [10:0] IRQ_VECTOR = 11'h008;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : osc_pmc_pkg

// >>> osc_pmc_div.sv
// Purpose: Instruction clock enable, system clock divided by 2 or 4
// Assumes: Runs on the system clock domain
// Notes:   Produces a one-cycle strobe, not a derived clock

`timescale 1ns/1ps
`default_nettype none

module osc_pmc_div (
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_ce,
   input  wire logic i_run,
   input  wire logic i_div4,
   output logic      o_tick
);
   logic [1:0] cnt_q;

   // Counter wraps at 1 or 3; stops when execution stops
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= 2'h0;
      end else if (i_ce) begin
         if (!i_run || cnt_q == (i_div4 ? 2'h3 : 2'h1)) cnt_q <= 2'h0;
         else cnt_q <= cnt_q + 2'h1;
      end
   end

   assign o_tick = i_run && (cnt_q == (i_div4 ? 2'h3 : 2'h1));
endmodule : osc_pmc_div

`default_nettype wire

// >>> osc_pmc.sv
// Purpose: Oscillator select and power-mode sequencer with three irq sources
// Assumes: Core signals are synchronous; event pins are asynchronous
// Notes:   Oscillators are modelled by enable outputs only
//
// Summary of operation
// - Low voltage sets flag; service needs enables
// - Comparator change raises irq when enabled
// - Reading mode register clears comparator difference
// - Conversion done raises irq when enabled
// - Fast RC frequency chosen by configuration
// - Slow clock is 32768 Hz RC
// - Bit 0 picks fast or slow clock
// - Instruction clock is system clock /2 or /4
// - Startup bit picks normal or slow
// - Mode field 10 enters standby
// - Sleep or 01 enters halt, sets status
// - Stop bit halts fast oscillator
// - Fast oscillator stopped automatically only in halt
// - Standby stops execution, keeps timers, slow RC
// - Standby wakes on timer, watchdog, change, pin
// - Wake resumes in mode of select bit
// - Halt disables both oscillators and peripherals
// - Halt wakes on watchdog, change, pin only
// - Halt wake waits 512 or 16 cycles
// - Standby wake needs no wait
// - Wake vectors to 0x008 when irqs enabled
// - Stop bit and halt in one write accepted

`timescale 1ns/1ps
`default_nettype none

module osc_pmc
   import osc_pmc_pkg::*;
#(
   parameter int WAKE_XTAL = WAKE_XTAL_CYC,
   parameter int WAKE_RC   = WAKE_RC_CYC
) (
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RST_B,
   input  wire logic        I_CE,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic [31:0]      O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   input  wire logic        I_LOW_VOLTAGE,
   input  wire logic        I_CMP_OUT,
   input  wire logic        I_ADC_EOC,
   input  wire logic        I_SLEEP_INSTR,
   input  wire logic        I_INSTR_DONE,
   input  wire logic        I_TIMER_WAKE,
   input  wire logic        I_WDT_WAKE,
   input  wire logic        I_PORT_CHANGE,
   input  wire logic        I_EXT_PIN,
   output logic             O_FAST_OSC_EN,
   output logic             O_SLOW_OSC_EN,
   output logic             O_SYS_CLK_FAST,
   output logic [2:0]       O_FAST_RC_CODE,
   output logic             O_INSTR_TICK,
   output logic             O_EXEC_RUN,
   output logic             O_PERIPH_EN,
   output logic             O_TIMERS_EN,
   output logic             O_IRQ_REQ,
   output logic             O_VECTOR_JUMP,
   output logic [10:0]      O_VECTOR_ADDR,
   output logic             O_WDT_CLEAR,
   output logic             O_POWER_DOWN_STATUS,
   output logic             O_TIMEOUT_STATUS
);

   typedef enum logic [1:0] {ST_RUN, ST_STANDBY, ST_HALT, ST_WAKE} pstate_e;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers for asynchronous pins
   logic [5:0] meta_q;
   logic [5:0] sync_q;
   logic       lvd_s, cmp_s, eoc_s, tmr_s, wdt_s, chg_s, pin_s;

   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         meta_q <= 6'h00;
         sync_q <= 6'h00;
      end else if (I_CE) begin
         meta_q <= {I_LOW_VOLTAGE, I_CMP_OUT, I_ADC_EOC, I_WDT_WAKE, I_PORT_CHANGE, I_EXT_PIN};
         sync_q <= meta_q;
      end
   end
   assign {lvd_s, cmp_s, eoc_s, wdt_s, chg_s, pin_s} = sync_q;
   assign tmr_s = I_TIMER_WAKE; // Timers share this clock

   ////////////////////////////////////////////////////////////////////////
   // APB decode
   logic wr_en, rd_en, hit;
   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
      is_reg = (a == ofs);
   endfunction
   assign wr_en = I_PSEL && I_PENABLE && I_PWRITE && I_CE;
   assign rd_en = I_PSEL && I_PENABLE && !I_PWRITE && I_CE;
   assign hit = is_reg(I_PADDR, OFS_OSC_MODE) || is_reg(I_PADDR, OFS_IRQ_CTRL) ||
                is_reg(I_PADDR, OFS_IRQ_FLAGS) || is_reg(I_PADDR, OFS_CONFIG) ||
                is_reg(I_PADDR, OFS_STATUS);
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = I_PSEL && I_PENABLE && !hit;

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic       sel_fast_q, stop_fast_q;
   logic [1:0] pend_mode_q;
   logic [3:0] irq_en_q;            // gie, lvd, cmp, adc enables
   logic [7:0] cfg_q;
   logic       cfg_started_q;
   pstate_e    st_q;
   logic       in_sleep;

   // Clock select and stop bit; stop only by explicit write
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         sel_fast_q  <= RST_OSC_MODE[FLD_SEL_FAST];
         stop_fast_q <= RST_OSC_MODE[FLD_STOP_FAST];
      end else if (I_CE) begin
         if (!cfg_started_q) sel_fast_q <= cfg_q[FLD_START_FAST];
         else if (wr_en && is_reg(I_PADDR, OFS_OSC_MODE)) begin
            sel_fast_q  <= I_PWDATA[FLD_SEL_FAST];
            stop_fast_q <= I_PWDATA[FLD_STOP_FAST];
         end
      end
   end

   // Configuration word, writable at any time; startup bit applied on first enabled cycle
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         cfg_q <= RST_CONFIG;
         cfg_started_q <= 1'b0;
      end else if (I_CE) begin
         cfg_started_q <= 1'b1;
         if (wr_en && is_reg(I_PADDR, OFS_CONFIG)) cfg_q <= I_PWDATA[7:0];
      end
   end

   // Interrupt enables; the core owns clearing the global enable when it vectors
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) irq_en_q <= 4'h0;
      else if (I_CE) begin
         if (wr_en && is_reg(I_PADDR, OFS_IRQ_CTRL)) irq_en_q <= I_PWDATA[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt flags; set wins over software clear
   logic [3:1] flag_q;
   logic       lvd_prev_q, cmp_ref_q, eoc_prev_q;
   logic       cmp_diff, lvd_ev, eoc_ev;
   logic [3:1] set_v, clr_v;
   logic       osc_rd;

   assign osc_rd = rd_en && is_reg(I_PADDR, OFS_OSC_MODE);
   assign lvd_ev = lvd_s && !lvd_prev_q;
   assign cmp_diff = cmp_s != cmp_ref_q;
   assign eoc_ev = eoc_s && !eoc_prev_q;
   assign set_v = {eoc_ev, cmp_diff, lvd_ev};
   assign clr_v = (wr_en && is_reg(I_PADDR, OFS_IRQ_FLAGS)) ? ~I_PWDATA[3:1] : 3'h0;

   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         lvd_prev_q <= 1'b0;
         eoc_prev_q <= 1'b0;
      end else if (I_CE) begin
         lvd_prev_q <= lvd_s;
         eoc_prev_q <= eoc_s;
      end
   end

   // Comparator reference only refreshed by a read, so difference stays
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) cmp_ref_q <= 1'b0;
      else if (I_CE && osc_rd) cmp_ref_q <= cmp_s;
   end

   genvar gi;
   generate
      for (gi = 1; gi <= 3; gi++) begin : g_flag
         always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
            if (!I_RST_B) flag_q[gi] <= 1'b0;
            else if (I_CE) begin
               if (set_v[gi]) flag_q[gi] <= 1'b1;
               else if (clr_v[gi]) flag_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Service only with source and global enables
   assign O_IRQ_REQ = irq_en_q[FLD_GIE] && |(flag_q & irq_en_q[3:1]) && !in_sleep;

   ////////////////////////////////////////////////////////////////////////
   // Power mode sequencer
   logic [9:0] wake_cnt_q;
   logic       gie_at_sleep_q, vec_q, wdt_clr_q, pd_q, to_q;
   logic       sb_wake, halt_wake, halt_req;
   logic [9:0] wake_len;

   // Mode field held pending until instruction completes
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) pend_mode_q <= PMODE_RUN;
      else if (I_CE) begin
         if (wr_en && is_reg(I_PADDR, OFS_OSC_MODE)) pend_mode_q <= I_PWDATA[FLD_MODE_LO +: 2];
         else if (I_INSTR_DONE && st_q == ST_RUN) pend_mode_q <= PMODE_RUN;
      end
   end

   assign halt_req = I_SLEEP_INSTR || (I_INSTR_DONE && pend_mode_q == PMODE_HALT);
   assign sb_wake = tmr_s || wdt_s || chg_s || pin_s;
   assign halt_wake = wdt_s || chg_s || pin_s;
   assign wake_len = cfg_q[FLD_XTAL] ? 10'(WAKE_XTAL - 1) : 10'(WAKE_RC - 1);
   assign in_sleep = (st_q == ST_STANDBY) || (st_q == ST_HALT);

   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         st_q <= ST_RUN;
         wake_cnt_q <= 10'h000;
      end else if (I_CE) begin
         case (st_q)
            ST_RUN: begin
               if (halt_req) st_q <= ST_HALT;
               else if (I_INSTR_DONE && pend_mode_q == PMODE_STANDBY) st_q <= ST_STANDBY;
            end
            ST_STANDBY: if (sb_wake) st_q <= ST_RUN;
            ST_HALT: begin
               if (halt_wake) begin
                  st_q <= ST_WAKE;
                  wake_cnt_q <= wake_len;
               end
            end
            ST_WAKE: begin
               if (wake_cnt_q == 10'h000) st_q <= ST_RUN;
               else wake_cnt_q <= wake_cnt_q - 10'h001;
            end
            default: st_q <= ST_RUN;
         endcase
      end
   end

   // Status bits and watchdog clear on halt entry
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         pd_q <= 1'b1;
         to_q <= 1'b1;
         wdt_clr_q <= 1'b0;
      end else if (I_CE) begin
         wdt_clr_q <= 1'b0;
         if (st_q == ST_RUN && halt_req) begin
            pd_q <= 1'b0;
            to_q <= 1'b1;
            wdt_clr_q <= 1'b1;
         end
      end
   end

   // Remember global enable at entry; vector on wake
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         gie_at_sleep_q <= 1'b0;
         vec_q <= 1'b0;
      end else if (I_CE) begin
         vec_q <= 1'b0;
         if (st_q == ST_RUN && (halt_req || (I_INSTR_DONE && pend_mode_q == PMODE_STANDBY)))
            gie_at_sleep_q <= irq_en_q[FLD_GIE];
         if ((st_q == ST_STANDBY && sb_wake) || (st_q == ST_WAKE && wake_cnt_q == 10'h000))
            vec_q <= gie_at_sleep_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock and gating outputs
   assign O_SYS_CLK_FAST = sel_fast_q;
   // Fast oscillator restarts during the wake count, or a fast system clock could never finish it
   assign O_FAST_OSC_EN = !stop_fast_q && st_q != ST_HALT;
   assign O_SLOW_OSC_EN = st_q != ST_HALT;
   assign O_FAST_RC_CODE = cfg_q[FLD_HRC_LO +: 3] > 3'h5 ? 3'h5 : cfg_q[FLD_HRC_LO +: 3];
   assign O_EXEC_RUN = st_q == ST_RUN;
   assign O_PERIPH_EN = st_q == ST_RUN;
   assign O_TIMERS_EN = st_q == ST_RUN || st_q == ST_STANDBY;
   assign O_VECTOR_JUMP = vec_q;
   assign O_VECTOR_ADDR = IRQ_VECTOR;
   assign O_WDT_CLEAR = wdt_clr_q;
   assign O_POWER_DOWN_STATUS = pd_q;
   assign O_TIMEOUT_STATUS = to_q;

   osc_pmc_div osc_pmc_div_inst (
      .i_clk   (I_SYS_CLK),
      .i_rst_b (I_RST_B),
      .i_ce    (I_CE),
      .i_run   (O_EXEC_RUN),
      .i_div4  (cfg_q[FLD_DIV4]),
      .o_tick  (O_INSTR_TICK)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read mux
   always_comb begin
      O_PRDATA = RD_ZERO;
      if (is_reg(I_PADDR, OFS_OSC_MODE))
         O_PRDATA[7:0] = {3'h0, cmp_s, pend_mode_q, stop_fast_q, sel_fast_q};
      else if (is_reg(I_PADDR, OFS_IRQ_CTRL)) O_PRDATA[3:0] = irq_en_q;
      else if (is_reg(I_PADDR, OFS_IRQ_FLAGS)) O_PRDATA[3:0] = {flag_q, 1'b0};
      else if (is_reg(I_PADDR, OFS_CONFIG)) O_PRDATA[7:0] = cfg_q;
      else if (is_reg(I_PADDR, OFS_STATUS)) O_PRDATA[3:0] = {to_q, pd_q, st_q};
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_halt_osc_off;
      @(posedge I_SYS_CLK) disable iff (!I_RST_B) st_q == ST_HALT |-> !O_FAST_OSC_EN && !O_SLOW_OSC_EN;
   endproperty
   a_halt_osc_off: assert property (p_halt_osc_off) else $error("osc on in halt");

   property p_irq_gate;
      @(posedge I_SYS_CLK) disable iff (!I_RST_B) O_IRQ_REQ |-> irq_en_q[FLD_GIE];
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");

   property p_halt_entry;
      @(posedge I_SYS_CLK) disable iff (!I_RST_B)
         I_CE && st_q == ST_RUN && halt_req |=> !pd_q && to_q && wdt_clr_q && st_q == ST_HALT;
   endproperty
   a_halt_entry: assert property (p_halt_entry) else $error("halt entry status wrong");

   property p_standby_no_wait;
      @(posedge I_SYS_CLK) disable iff (!I_RST_B) I_CE && st_q == ST_STANDBY && sb_wake |=> st_q == ST_RUN;
   endproperty
   a_standby_no_wait: assert property (p_standby_no_wait) else $error("standby wake delayed");

   property p_halt_wake_src;
      @(posedge I_SYS_CLK) disable iff (!I_RST_B) st_q == ST_HALT && $past(st_q) == ST_HALT && tmr_s && !halt_wake |=> st_q == ST_HALT;
   endproperty
   a_halt_wake_src: assert property (p_halt_wake_src) else $error("timer woke halt");

   property p_stop_only_bit;
      @(posedge I_SYS_CLK) disable iff (!I_RST_B) st_q == ST_STANDBY && !stop_fast_q |-> O_FAST_OSC_EN;
   endproperty
   a_stop_only_bit: assert property (p_stop_only_bit) else $error("fast osc stopped automatically");

   property p_rc_wake;
      @(posedge I_SYS_CLK) disable iff (!I_RST_B)
         I_CE && st_q == ST_HALT && halt_wake && !cfg_q[FLD_XTAL] && WAKE_RC == 16 |=> ##16 st_q == ST_RUN;
   endproperty
   a_rc_wake: assert property (p_rc_wake) else $error("rc wake time wrong");

   property p_cmp_sticky;
      @(posedge I_SYS_CLK) disable iff (!I_RST_B) I_CE && cmp_diff |=> flag_q[FLD_CMP];
   endproperty
   a_cmp_sticky: assert property (p_cmp_sticky) else $error("comparator flag lost");
endmodule : osc_pmc

`default_nettype wire

// >>> osc_pmc_core_model.sv
// Purpose: Behavioural stand-in for the processor core beside the controller
// Assumes: One instruction completes on the cycle after each instruction tick
// Notes:   Sleep is issued once per request, always at an instruction boundary

`timescale 1ns/1ps
`default_nettype none

module osc_pmc_core_model (
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_tick,
   input  wire logic i_sleep_req,
   output logic      o_instr_done,
   output logic      o_sleep_instr
);
   logic sent_q;

   ////////////////////////////////////////////////////////////////////////////
   // Completion strobe; no tick in standby or halt means no instruction ends
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_instr_done <= 1'b0;
      end else begin
         o_instr_done <= i_tick;
      end
   end

   // Single sleep pulse; re-arming waits for the request to drop, so no double entry
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_sleep_instr <= 1'b0;
         sent_q        <= 1'b0;
      end else begin
         o_sleep_instr <= i_tick & i_sleep_req & ~sent_q;
         sent_q        <= i_sleep_req & (sent_q | i_tick);
      end
   end
endmodule : osc_pmc_core_model

`default_nettype wire

// >>> test_osc_pmc.sv
// Purpose: Self-checking bench for the oscillator and power-mode controller
// Assumes: APB slave answers in the first access cycle; wake events are levels
// Notes:   Wake waits use the default 16 and 512 cycle stable times

`timescale 1ns/1ps
`default_nettype none

module test_osc_pmc;
   import osc_pmc_pkg::*;
   logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, err, low_v = 0, cmp = 0, eoc = 0, sleep_req = 0;
   logic        tmr_w = 0, wdt_w = 0, port_w = 0, ext_w = 0, sleep_instr, instr_done;
   logic        fast_en, slow_en, clk_fast, tick, exec_run, periph_en, timers_en;
   logic        irq, vjump, wdt_clr, pd, to;
   logic [2:0]  rc_code;
   logic [10:0] vaddr, vaddr_seen = 0;
   int          miscompares = 0, samples_checked = 0, vj_cnt = 0, clr_cnt = 0, n;

   osc_pmc osc_pmc_inst (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_CE(1'b1), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_LOW_VOLTAGE(low_v),
      .I_CMP_OUT(cmp), .I_ADC_EOC(eoc), .I_SLEEP_INSTR(sleep_instr), .I_INSTR_DONE(instr_done),
      .I_TIMER_WAKE(tmr_w), .I_WDT_WAKE(wdt_w), .I_PORT_CHANGE(port_w), .I_EXT_PIN(ext_w),
      .O_FAST_OSC_EN(fast_en), .O_SLOW_OSC_EN(slow_en), .O_SYS_CLK_FAST(clk_fast),
      .O_FAST_RC_CODE(rc_code), .O_INSTR_TICK(tick), .O_EXEC_RUN(exec_run),
      .O_PERIPH_EN(periph_en), .O_TIMERS_EN(timers_en), .O_IRQ_REQ(irq),
      .O_VECTOR_JUMP(vjump), .O_VECTOR_ADDR(vaddr), .O_WDT_CLEAR(wdt_clr),
      .O_POWER_DOWN_STATUS(pd), .O_TIMEOUT_STATUS(to));

   osc_pmc_core_model osc_pmc_core_model_inst (.i_clk(clk), .i_rst_b(rst_b), .i_tick(tick),
      .i_sleep_req(sleep_req), .o_instr_done(instr_done), .o_sleep_instr(sleep_instr));

   ////////////////////////////////////////////////////////////////////////////
   // Clock and pulse monitors; one-cycle pulses are only seen by counting
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (vjump === 1'b1) begin
         vj_cnt++;
         vaddr_seen = vaddr;
      end
      if (wdt_clr === 1'b1) clr_cnt++;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One APB transfer; request held until pready is seen high at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(negedge clk);  // Write has landed; callers may now look at outputs
   endtask : xfer

   task automatic wait_run(input logic lvl);
      n = 0;
      while (exec_run !== lvl && n < 1000) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_run

   task automatic ticks(input int exp);
      n = 0;
      repeat (8) @(posedge clk);
      repeat (40) begin
         @(negedge clk);
         n += (tick === 1'b1);
      end
      chk("tick count", exp, n);
   endtask : ticks

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      xfer(0, OFS_OSC_MODE, 0);   chk("mode reg", 32'h0000_0001, rd);
      xfer(0, OFS_CONFIG, 0);     chk("config", 32'h0000_0010, rd);
      xfer(0, OFS_STATUS, 0);     chk("status", 32'h0000_000c, rd);
      xfer(0, 8'h14, 0);          chk("unmapped", 32'h0000_0001, {rd[30:0], err});
      chk("fast sel", 1, clk_fast);
   endtask : t_reset

   task automatic t_clock;
      xfer(1, OFS_OSC_MODE, 32'h00);  chk("slow sel", 0, clk_fast);
      chk("fast kept", 1, fast_en);
      xfer(1, OFS_OSC_MODE, 32'h02);  chk("fast stop", 0, fast_en);
      xfer(1, OFS_OSC_MODE, 32'h00);  chk("fast on", 1, fast_en);
      xfer(1, OFS_OSC_MODE, 32'h01);  chk("fast sel", 1, clk_fast);
      chk("slow rc", 1, slow_en);
      ticks(20);
      xfer(1, OFS_CONFIG, 32'h1d);  chk("rc code", 5, rc_code);
      ticks(10);
      xfer(1, OFS_CONFIG, 32'h12);  chk("rc code", 2, rc_code);
   endtask : t_clock

   task automatic t_irq;
      xfer(1, OFS_IRQ_CTRL, 32'h0d);
      @(posedge clk) low_v <= 1'b1;
      repeat (5) @(posedge clk);
      xfer(0, OFS_IRQ_FLAGS, 0);  chk("lvd flag", 32'h2, rd & 32'h2);
      chk("masked", 0, irq);
      xfer(1, OFS_IRQ_CTRL, 32'h0f);  chk("lvd req", 1, irq);
      xfer(1, OFS_IRQ_CTRL, 32'h02);  chk("no global", 0, irq);
      xfer(1, OFS_IRQ_FLAGS, 0);
      xfer(1, OFS_IRQ_CTRL, 32'h09);
      @(posedge clk) eoc <= 1'b1;
      repeat (4) @(posedge clk) eoc <= 1'b0;
      xfer(0, OFS_IRQ_FLAGS, 0);  chk("adc flag", 32'h8, rd);
      chk("adc req", 1, irq);
      xfer(1, OFS_IRQ_FLAGS, 0);
      xfer(1, OFS_IRQ_CTRL, 32'h05);
      xfer(0, OFS_OSC_MODE, 0);
      xfer(1, OFS_IRQ_FLAGS, 0);  chk("cmp idle", 0, irq);
      @(posedge clk) cmp <= 1'b1;
      repeat (5) @(posedge clk);
      chk("cmp req", 1, irq);
      xfer(0, OFS_OSC_MODE, 0);  chk("cmp level", 32'h11, rd);
      xfer(1, OFS_IRQ_FLAGS, 0);
      xfer(0, OFS_IRQ_FLAGS, 0);  chk("cmp cleared", 0, rd);
      xfer(1, OFS_IRQ_CTRL, 32'h01);
   endtask : t_irq

   task automatic t_standby;
      xfer(1, OFS_OSC_MODE, 32'h09);
      wait_run(0);
      chk("stopped", 0, {exec_run, periph_en});
      chk("kept on", 32'h7, {timers_en, slow_en, fast_en});
      @(posedge clk) tmr_w <= 1'b1;
      wait_run(1);
      chk("no wait", 1, n <= 6);
      @(posedge clk) tmr_w <= 1'b0;
      chk("normal", 1, clk_fast);
      repeat (3) @(posedge clk);
      chk("vector", 32'h1, vj_cnt);
      chk("vector addr", 32'h008, vaddr_seen);
   endtask : t_standby

   task automatic t_halt_rc;
      xfer(1, OFS_IRQ_CTRL, 0);
      xfer(1, OFS_OSC_MODE, 32'h00);
      @(posedge clk) sleep_req <= 1'b1;
      wait_run(0);
      @(posedge clk) sleep_req <= 1'b0;
      repeat (2) @(posedge clk);
      chk("halt off", 0, {fast_en, slow_en, periph_en, timers_en, exec_run});
      chk("pd to", 32'h1, {pd, to});
      chk("wdt clear", 1, clr_cnt);
      @(posedge clk) tmr_w <= 1'b1;
      repeat (10) @(posedge clk);
      chk("timer no wake", 0, exec_run);
      tmr_w  <= 1'b0;
      port_w <= 1'b1;
      wait_run(1);
      chk("rc wait", 1, n >= WAKE_RC_CYC && n <= WAKE_RC_CYC + 8);
      @(posedge clk) port_w <= 1'b0;
      chk("slow resume", 0, clk_fast);
      chk("no vector", 1, vj_cnt);
   endtask : t_halt_rc

   task automatic t_halt_xtal;
      // Slow clock first; stopping the fast one while it drives execution could hang
      xfer(1, OFS_OSC_MODE, 32'h00);
      xfer(1, OFS_CONFIG, 32'h30);
      xfer(1, OFS_OSC_MODE, 32'h06);
      wait_run(0);
      chk("halt entered", 0, {slow_en, exec_run});
      @(posedge clk) ext_w <= 1'b1;
      wait_run(1);
      chk("xtal wait", 1, n >= WAKE_XTAL_CYC && n <= WAKE_XTAL_CYC + 8);
      @(posedge clk) ext_w <= 1'b0;
      chk("stop held", 0, fast_en);
      xfer(1, OFS_OSC_MODE, 32'h01);  chk("fast back", 1, fast_en);
   endtask : t_halt_xtal

   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict

   // Main sequence; halt waits dominate the run length
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      t_reset;
      t_clock;
      t_irq;
      t_standby;
      t_halt_rc;
      t_halt_xtal;
      give_verdict;
   end

   // Hang guard, about 25 times the expected run
   initial begin
      #(25 * 20000);
      miscompares++;
      give_verdict;
   end
endmodule : test_osc_pmc

`default_nettype wire
